/* tb/uart_interrupt_ready_logic_tb.sv */
// Self-checking bench for the UART interrupt and ready logic.
`timescale 1ns/1ps
module uart_interrupt_ready_logic_tb
  import uirl_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irqN, txReadyN, rxReadyN;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  uirl_core_s core;
  int fails = 0;
  int checksDone = 0;
  always #25 clk = ~clk;
  uirl_core_model model (.clk(clk), .core(core));
  uirl_top #(.FIFO_DEPTH(5'h10)) uut (.clk(clk), .rstn(rstn), .core(core), .irqN(irqN),
    .txReadyN(txReadyN), .rxReadyN(rxReadyN), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task close_out;
    $display("Checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask : wr
  task rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask : rd
  task t_reset;
    rd(OFS_MASK, 32'h0, RESP_OKAY);
    rd(OFS_ISRC, 32'h01, RESP_OKAY);
    wr(OFS_MASK, 32'hFF, RESP_OKAY);
    rd(OFS_MASK, 32'h0F, RESP_OKAY);
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    wr(5'h18, 32'h1, RESP_SLVERR);
    rd(5'h18, 32'h0, RESP_SLVERR);
  endtask : t_reset
  task t_lsr;
    model.put(5'h01, 5'h00, 4'hA, 4'h0);
    rd(OFS_LSTAT, 32'hF5, RESP_OKAY);
    model.put(5'h00, 5'h02, 4'h0, 4'h0);
    rd(OFS_LSTAT, 32'h00, RESP_OKAY);
  endtask : t_lsr
  task t_prio;
    wr(OFS_MASK, 32'h0F, RESP_OKAY);
    model.put(5'h01, 5'h00, 4'h2, 4'h1);
    rd(OFS_ISRC, 32'h06, RESP_OKAY);
    chk(irqN, 1'b0);
    model.put(5'h01, 5'h00, 4'h0, 4'h1);
    rd(OFS_ISRC, 32'h04, RESP_OKAY);
    model.put(5'h00, 5'h00, 4'h0, 4'h1);
    rd(OFS_ISRC, 32'h02, RESP_OKAY);
    model.put(5'h00, 5'h03, 4'h0, 4'h1);
    rd(OFS_ISRC, 32'h00, RESP_OKAY);
    model.put(5'h00, 5'h03, 4'h0, 4'h0);
    rd(OFS_ISRC, 32'h01, RESP_OKAY);
    chk(irqN, 1'b1);
  endtask : t_prio
  task t_fifo_rx;
    wr(OFS_FCTL, 32'h01, RESP_OKAY);
    wr(OFS_TRIG, 32'h04, RESP_OKAY);
    wr(OFS_MASK, 32'h01, RESP_OKAY);
    model.put(5'h03, 5'h05, 4'h0, 4'h0);
    rd(OFS_ISRC, 32'hC1, RESP_OKAY);
    chk(irqN, 1'b1);
    model.put(5'h04, 5'h05, 4'h0, 4'h0);
    rd(OFS_ISRC, 32'hC4, RESP_OKAY);
    chk(irqN, 1'b0);
    model.put(5'h03, 5'h05, 4'h0, 4'h0);
    model.set_timeout(1'b1);
    rd(OFS_ISRC, 32'hCC, RESP_OKAY);
    chk(irqN, 1'b0);
    model.set_timeout(1'b0);
  endtask : t_fifo_rx
  task t_fifo_tx;
    wr(OFS_MASK, 32'h02, RESP_OKAY);
    model.put(5'h00, 5'h01, 4'h0, 4'h0);
    model.put(5'h00, 5'h00, 4'h0, 4'h0);
    rd(OFS_ISRC, 32'hC2, RESP_OKAY);
    rd(OFS_ISRC, 32'hC1, RESP_OKAY);
    model.put(5'h00, 5'h01, 4'h0, 4'h0);
    model.put(5'h00, 5'h00, 4'h0, 4'h0);
    model.send_char();
    rd(OFS_ISRC, 32'hC1, RESP_OKAY);
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    model.put(5'h01, 5'h00, 4'h1, 4'h1);
    repeat (4) @(posedge clk);
    chk(irqN, 1'b1);
  endtask : t_fifo_tx
  task t_dma;
    wr(OFS_FCTL, 32'h09, RESP_OKAY);
    model.put(5'h00, 5'h10, 4'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk(txReadyN, 1'b1);
    model.put(5'h04, 5'h0F, 4'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk({txReadyN, rxReadyN}, 2'b00);
    model.put(5'h00, 5'h0F, 4'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk(rxReadyN, 1'b1);
    wr(OFS_FCTL, 32'h01, RESP_OKAY);
    model.put(5'h01, 5'h00, 4'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk({txReadyN, rxReadyN}, 2'b00);
    model.send_char();
    repeat (2) @(posedge clk);
    chk(txReadyN, 1'b1);
  endtask : t_dma
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_lsr();
    t_prio();
    t_fifo_rx();
    t_fifo_tx();
    t_dma();
    close_out();
  end
  initial begin
    #2000000;
    fails++;
    close_out();
  end
endmodule : uart_interrupt_ready_logic_tb

/* tb/uirl_asserts.sv */
// Checker for the interrupt, ready pin and write answer ports.
`timescale 1ns/1ps
module uirl_asserts
  import uirl_pkg::*;
#(
  parameter logic [CNT_W-1:0] FIFO_DEPTH = 5'h10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire uirl_core_s core,
  input wire logic irqN,
  input wire logic txReadyN,
  input wire logic rxReadyN,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid
);
  // Mirrors only see writes whose address and data meet on one edge.
  logic [3:0] mask;
  logic [7:0] fctl;
  wire wTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire wOk = wTake && s_axi_wstrb[0];
  wire dma1 = fctl[FCTL_FIFO_EN] && fctl[FCTL_DMA1];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mask <= MASK_RST;
    else if (wOk && s_axi_awaddr == OFS_MASK) mask <= s_axi_wdata[3:0];
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) fctl <= FCTL_RST;
    else if (wOk && s_axi_awaddr == OFS_FCTL) fctl <= s_axi_wdata[7:0];
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence dma0Held_s;
    (!dma1) [*3];
  endsequence
  sequence dma1Held_s;
    dma1 [*3];
  endsequence
  irq_quiet_a:
    assert property ((mask == 4'h0) [*3] |=> irqN) else $error("irq with masks clear");
  modem_irq_a:
    assert property ((mask[MASK_MS] && core.modemDelta != 4'h0) [*3] |=> !irqN)
    else $error("modem irq missing");
  line_irq_a:
    assert property ((mask[MASK_LS] && core.rxErr != 4'h0) [*3] |=> !irqN)
    else $error("line irq missing");
  tx_dma0_a:
    assert property (dma0Held_s |=>
      txReadyN == !($past(core.txCount) == 5'h00 && !$past(core.thrWrite)))
    else $error("tx ready mode 0 wrong");
  rx_dma0_a:
    assert property (dma0Held_s |=> rxReadyN == ($past(core.rxCount) == 5'h00))
    else $error("rx ready mode 0 wrong");
  tx_dma1_a:
    assert property (dma1Held_s |=> txReadyN == ($past(core.txCount) >= FIFO_DEPTH))
    else $error("tx ready mode 1 wrong");
  rx_dma1_a:
    assert property (dma1Held_s ##0 core.rxCount == 5'h00 |=> rxReadyN)
    else $error("rx ready mode 1 not released");
  // The answer is raised on the edge after both halves are held.
  write_answer_a:
    assert property (wTake |=> ##1 s_axi_bvalid) else $error("write answer late");
endmodule : uirl_asserts

bind uirl_top uirl_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.*);

/* tb/uirl_core_model.sv */
// Behavioural channel core that feeds status levels and write pulses.
`timescale 1ns/1ps
module uirl_core_model
  import uirl_pkg::*;
(
  input wire logic clk,
  output uirl_core_s core
);
  initial core = '0;
  // The shifter is taken as busy whenever characters wait, a simplification.
  task put(input logic [4:0] rx, input logic [4:0] tx, input logic [3:0] err,
      input logic [3:0] dl);
    @(posedge clk);
    core.rxCount <= rx;
    core.txCount <= tx;
    core.txShiftEmpty <= (tx == 5'h00);
    core.rxErr <= err;
    core.fifoDataErr <= (err != 4'h0);
    core.modemDelta <= dl;
    core.modemLines <= ~dl;
  endtask : put
  task set_timeout(input logic t);
    @(posedge clk);
    core.rxTimeout <= t;
  endtask : set_timeout
  task send_char;
    @(posedge clk);
    core.thrWrite <= 1'b1;
    core.txCount <= core.txCount + 5'h01;
    core.txShiftEmpty <= 1'b0;
    @(posedge clk);
    core.thrWrite <= 1'b0;
  endtask : send_char
endmodule : uirl_core_model

/* verilog/uirl_pkg.sv */
// Shared constants and carrier types for the UART interrupt and ready logic.
package uirl_pkg;

  localparam int ADDR_W = 5;
  localparam int CNT_W = 5;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_FCTL = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_ISRC = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_LSTAT = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_MSTAT = 5'h14;

  // Reset values.
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [7:0] FCTL_RST = 8'h00;
  localparam logic [CNT_W-1:0] TRIG_RST = 5'h01;
  localparam logic [7:0] ISRC_RST = 8'h01;

  // Field positions.
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LS = 2;
  localparam int MASK_MS = 3;
  localparam int FCTL_FIFO_EN = 0;
  localparam int FCTL_DMA1 = 3;

  // Interrupt source codes, bit 0 high means nothing pending.
  localparam logic [3:0] SRC_NONE = 4'h1;
  localparam logic [3:0] SRC_LINE = 4'h6;
  localparam logic [3:0] SRC_RX = 4'h4;
  localparam logic [3:0] SRC_TIMEOUT = 4'hC;
  localparam logic [3:0] SRC_TX = 4'h2;
  localparam logic [3:0] SRC_MODEM = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status from the channel core, all on the same clock.
  typedef struct packed {
    logic [CNT_W-1:0] rxCount;
    logic [CNT_W-1:0] txCount;
    logic txShiftEmpty;
    logic [3:0] rxErr;
    logic fifoDataErr;
    logic [3:0] modemDelta;
    logic [3:0] modemLines;
    logic rxTimeout;
    logic thrWrite;
  } uirl_core_s;

endpackage : uirl_pkg

/* verilog/uirl_top.sv */
// Interrupt masking, source reporting and DMA ready pins for one UART channel.
`timescale 1ns/1ps

module uirl_top
  import uirl_pkg::*;
#(
  parameter logic [CNT_W-1:0] FIFO_DEPTH = 5'h10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire uirl_core_s core,
  output logic irqN,
  output logic txReadyN,
  output logic rxReadyN,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state, bus handshake holding and internal decode signals.

  logic [3:0] mask_reg;
  logic [7:0] fctl_reg;
  logic [CNT_W-1:0] trig_reg;
  logic txPend_reg;
  logic txEmptyPrev_reg;

  logic [ADDR_W-1:0] awAddr_reg;
  logic awHeld_reg;
  logic [7:0] wData_reg;
  logic wLane0_reg;
  logic wHeld_reg;

  logic fifoEn;
  logic dmaMode1;
  logic rxAvail;
  logic rxAtTrig;
  logic txEmpty;
  logic txFull;
  logic txSource;
  logic rxSource;
  logic lineSource;
  logic modemSource;
  logic timeoutSource;
  logic anySource;
  logic [3:0] srcCode;
  logic [7:0] isrValue;
  logic [7:0] lsrValue;
  logic [7:0] msrValue;
  logic doWrite;
  logic doRead;
  logic isrRead;
  logic [7:0] readValue;
  logic readHit;

  assign fifoEn = fctl_reg[FCTL_FIFO_EN];
  assign dmaMode1 = fifoEn & fctl_reg[FCTL_DMA1];
  assign rxAvail = core.rxCount != '0;
  assign txEmpty = core.txCount == '0;
  assign txFull = core.txCount >= FIFO_DEPTH;

  // Without FIFOs the holding register is a one-deep queue, so any data
  // counts as having reached the trigger.
  assign rxAtTrig = fifoEn ? (core.rxCount >= trig_reg) : rxAvail;

  ////////////////////////////////////////////////////////////////////////////
  // Status registers as the host sees them.

  always_comb begin
    lsrValue = '0;
    lsrValue[0] = rxAvail;
    lsrValue[4:1] = core.rxErr;
    lsrValue[5] = txEmpty;
    lsrValue[6] = txEmpty & core.txShiftEmpty;
    lsrValue[7] = core.fifoDataErr;
  end

  assign msrValue = {core.modemLines, core.modemDelta};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources.

  // A level follows the holding register; in FIFO mode only the drain
  // edge counts, so a host that already saw it is not pestered again.
  assign txSource = mask_reg[MASK_TX] & (fifoEn ? txPend_reg : txEmpty);
  assign rxSource = mask_reg[MASK_RX] & rxAtTrig;
  assign timeoutSource = mask_reg[MASK_RX] & fifoEn & core.rxTimeout & rxAvail;
  assign lineSource = mask_reg[MASK_LS] & (|core.rxErr);
  assign modemSource = mask_reg[MASK_MS] & (|core.modemDelta);
  assign anySource = txSource | rxSource | timeoutSource | lineSource | modemSource;

  always_comb begin
    if (lineSource) begin
      srcCode = SRC_LINE;
    end else if (rxSource) begin
      srcCode = SRC_RX;
    end else if (timeoutSource) begin
      srcCode = SRC_TIMEOUT;
    end else if (txSource) begin
      srcCode = SRC_TX;
    end else if (modemSource) begin
      srcCode = SRC_MODEM;
    end else begin
      srcCode = SRC_NONE;
    end
  end

  assign isrValue = {fifoEn, fifoEn, 2'b00, srcCode};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txEmptyPrev_reg <= 1'b1;
    end else begin
      txEmptyPrev_reg <= txEmpty;
    end
  end

  // A new drain edge in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txPend_reg <= 1'b0;
    end else if (txEmpty & ~txEmptyPrev_reg) begin
      txPend_reg <= 1'b1;
    end else if (isrRead | core.thrWrite) begin
      txPend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqN <= 1'b1;
    end else begin
      irqN <= ~anySource;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA ready pins.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txReadyN <= 1'b1;
    end else if (dmaMode1) begin
      txReadyN <= txFull;
    end else begin
      // The write pulse raises the pin before the count catches up.
      txReadyN <= ~(txEmpty & ~core.thrWrite);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxReadyN <= 1'b1;
    end else if (dmaMode1) begin
      if (!rxAvail) begin
        rxReadyN <= 1'b1;
      end else if ((core.rxCount >= trig_reg) | core.rxTimeout) begin
        rxReadyN <= 1'b0;
      end
    end else begin
      rxReadyN <= ~rxAvail;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data are taken independently.

  assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (s_axi_awvalid & s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wLane0_reg <= 1'b0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata[7:0];
      wLane0_reg <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~awHeld_reg & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~wHeld_reg & ~(s_axi_wvalid & s_axi_wready);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      case (awAddr_reg)
        OFS_MASK, OFS_FCTL, OFS_TRIG, OFS_ISRC, OFS_LSTAT, OFS_MSTAT: begin
          s_axi_bresp <= RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= MASK_RST;
      fctl_reg <= FCTL_RST;
      trig_reg <= TRIG_RST;
    end else if (doWrite & wLane0_reg) begin
      case (awAddr_reg)
        OFS_MASK: begin
          mask_reg <= wData_reg[3:0];
        end
        OFS_FCTL: begin
          fctl_reg <= wData_reg;
        end
        OFS_TRIG: begin
          // Zero would hold the receive sources on with an empty FIFO.
          trig_reg <= (wData_reg[CNT_W-1:0] == '0) ? TRIG_RST : wData_reg[CNT_W-1:0];
        end
        default: begin
          mask_reg <= mask_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: one cycle from address to data.

  assign doRead = s_axi_arvalid & s_axi_arready;
  assign isrRead = doRead & (s_axi_araddr == OFS_ISRC);

  always_comb begin
    readHit = 1'b1;
    case (s_axi_araddr)
      OFS_MASK: begin
        readValue = {4'h0, mask_reg};
      end
      OFS_FCTL: begin
        readValue = fctl_reg;
      end
      OFS_TRIG: begin
        readValue = {3'h0, trig_reg};
      end
      OFS_ISRC: begin
        readValue = isrValue;
      end
      OFS_LSTAT: begin
        readValue = lsrValue;
      end
      OFS_MSTAT: begin
        readValue = msrValue;
      end
      default: begin
        readValue = 8'h00;
        readHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~doRead;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, readValue};
      s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : uirl_top
